//--- rtl/lcd_driver_config_regs.sv
// Purpose: Configuration registers and timing of a segment LCD driver
// Assumes: External reference is a level synchronous to mclk
// Notes:   Timing dividers are enables; one clock domain only
// Notes on behaviour
// - Source bit clear picks external reference, set picks bus clock
// - Divide-by-sixteen bit and six-bit adjust make the base clock
// - Pump enable bit set turns the charge pump on
// - Pump multiplier bit: zero doubler, one tripler
// - Bypass bit: zero buffered supply, one unbuffered
// - Supply code 00 derives second bias level from main supply
// - Supply code 10 expects power from the external supply pin
// - Multiplier select ignored while supply code is 00 (second bias from main)
// - Two-bit pump clock adjust chooses the pump clock source
// - Duty code 11 gives four backplanes, 10 gives three
// - Three-bit frame clock field divides the base frequency
// - Three-bit blink rate divides the frame-related base rate
// - Blink scope: zero selected segments, one all segments
// - Wait disable set stops driving during wait mode
// - Stop3 disable clear keeps driving during stop3
// - Each of 41 frontplanes has its own enable bit
// - Stop3 disable set stops driving during stop3
// - Supply code 01 generates third bias level from main supply
module lcd_driver_config_regs
  import lcd_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  // Register port
  input  wire logic [lcd_cfg_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [lcd_cfg_pkg::DATA_W-1:0] regWrData,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output logic      [lcd_cfg_pkg::DATA_W-1:0] regRdData,
  // Clock reference and power modes
  input  wire logic                      extRefClk,
  input  wire logic                      waitMode,
  input  wire logic                      stop3Mode,
  // Drive controls toward the glass
  output lcd_cfg_pkg::lcd_drive_t        driveCtrl,
  output logic      [lcd_cfg_pkg::FP_NUM-1:0] frontplaneDrive
);
  import lcd_cfg_pkg::*;

  logic [7:0]        clockSelReg;
  logic [7:0]        supplyReg;
  logic [7:0]        lowPowerReg;
  logic [7:0]        frameReg;
  logic [7:0]        blinkReg;
  logic [7:0]        fpReg [0:5];
  logic [FP_NUM-1:0] fpEnable;
  logic              extRefPrev;
  logic              selTick;
  logic              preTick;
  logic              baseTick;
  logic              frameTick;
  logic              active;
  logic [3:0]        pre16Cnt;
  logic [5:0]        adjCnt;
  logic [7:0]        frameCnt;
  logic [7:0]        frameMask;
  logic [9:0]        blinkCnt;
  logic [9:0]        blinkMask;
  logic              blinkPhase;
  logic [1:0]        bpIdx;
  logic [1:0]        bpLast;
  logic [2:0]        fpSel;

  // Register writes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clockSelReg <= RST_REG;
      supplyReg   <= RST_REG;
      lowPowerReg <= RST_REG;
      frameReg    <= RST_REG;
      blinkReg    <= RST_REG;
    end else if (regWrite) begin
      case (regAddr)
        IDX_CLOCK_SELECT: clockSelReg <= regWrData;
        IDX_SUPPLY:       supplyReg   <= regWrData;
        IDX_LOW_POWER:    lowPowerReg <= regWrData & 8'h03;
        IDX_FRAME:        frameReg    <= regWrData & FR_MASK;
        IDX_BLINK:        blinkReg    <= regWrData & BL_MASK;
        default: ;
      endcase
    end
  end

  assign fpSel = 3'(regAddr - IDX_FRONTPLANE_0);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < 6; i++) begin
        fpReg[i] <= RST_REG;
      end
    end else if (regWrite && regAddr >= IDX_FRONTPLANE_0
                 && regAddr <= IDX_FRONTPLANE_5) begin
      fpReg[fpSel] <= (regAddr == IDX_FRONTPLANE_5) ?
                      (regWrData & FP5_MASK) : regWrData;
    end
  end

  assign fpEnable = {fpReg[5][0], fpReg[4], fpReg[3], fpReg[2],
                     fpReg[1], fpReg[0]};

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        IDX_CLOCK_SELECT: regRdData <= clockSelReg;
        IDX_SUPPLY:       regRdData <= supplyReg;
        IDX_LOW_POWER:    regRdData <= lowPowerReg;
        IDX_FRAME:        regRdData <= frameReg;
        IDX_BLINK:        regRdData <= blinkReg;
        4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha: regRdData <= fpReg[fpSel];
        default:          regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // Driving stops in a low-power mode only when its disable bit is set
  assign active = !(waitMode && lowPowerReg[LP_WAIT_DIS_BIT])
               && !(stop3Mode && lowPowerReg[LP_STOP3_DIS_BIT]);

  // Clock source: every mclk cycle or each rising reference edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      extRefPrev <= 1'b0;
    end else begin
      extRefPrev <= extRefClk;
    end
  end

  assign selTick = clockSelReg[CLK_SOURCE_BIT] ? 1'b1
                 : (extRefClk && !extRefPrev);

  // Prescaler; counters hold while the display is stopped
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pre16Cnt <= 4'h0;
    end else if (active && selTick) begin
      pre16Cnt <= pre16Cnt + 4'h1;
    end
  end

  assign preTick = clockSelReg[CLK_PRESCALE_BY_SIXTEEN_BIT] ?
                   (selTick && pre16Cnt == PRE16_LAST) : selTick;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      adjCnt <= 6'h00;
    end else if (active && preTick) begin
      adjCnt <= (adjCnt >= clockSelReg[CLK_ADJ_MSB:0]) ? 6'h00
                : adjCnt + 6'h01;
    end
  end

  // Base tick: prescaled clock divided by adjust plus one
  assign baseTick = active && preTick
                 && adjCnt >= clockSelReg[CLK_ADJ_MSB:0];

  // Frame tick: base divided by two to the power of field plus one
  assign frameMask = 8'((FRAME_ONE << frameReg[FR_CLK_MSB:FR_CLK_LSB])
                        - 8'h01);
  assign frameTick = baseTick && ((frameCnt & frameMask) == frameMask);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      frameCnt <= 8'h00;
    end else if (baseTick) begin
      frameCnt <= frameCnt + 8'h01;
    end
  end

  // Blink phase toggles at a power-of-two division of the frame rate
  assign blinkMask = 10'((BLINK_ONE << blinkReg[BL_RATE_MSB:0]) - 10'h001);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      blinkCnt   <= 10'h000;
      blinkPhase <= 1'b0;
    end else if (frameTick) begin
      blinkCnt <= blinkCnt + 10'h001;
      if ((blinkCnt & blinkMask) == blinkMask) begin
        blinkPhase <= !blinkPhase;
      end
    end
  end

  // Backplane sequence length follows the duty code
  assign bpLast = frameReg[FR_DUTY_MSB:0];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bpIdx <= 2'h0;
    end else if (frameTick) begin
      bpIdx <= (bpIdx >= bpLast) ? 2'h0 : bpIdx + 2'h1;
    end
  end

  // Registered drive controls
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      driveCtrl <= '0;
    end else begin
      driveCtrl.lcdActive    <= active;
      driveCtrl.pumpOn       <= supplyReg[SUP_PUMP_EN_BIT];
      // Multiplier meaningless when second bias is taken from main supply
      driveCtrl.pumpTripler  <= supplyReg[SUP_PUMP_MUL_BIT]
        && supplyReg[SUP_SRC_MSB:0] != SUP_SECOND_BIAS;
      driveCtrl.pumpClockSel <= supplyReg[SUP_PCLK_MSB:SUP_PCLK_LSB];
      driveCtrl.highDrive    <= supplyReg[SUP_HDRV_BIT];
      driveCtrl.bufferBypass <= supplyReg[SUP_BYPASS_BIT];
      driveCtrl.secondBiasInternal <=
        supplyReg[SUP_SRC_MSB:0] == SUP_SECOND_BIAS;
      driveCtrl.thirdBiasInternal <=
        supplyReg[SUP_SRC_MSB:0] == SUP_THIRD_BIAS;
      driveCtrl.externalSupply <=
        supplyReg[SUP_SRC_MSB:0] == SUP_EXTERNAL;
      driveCtrl.quarterDuty  <= bpLast == DUTY_QUARTER;
      driveCtrl.backplaneCount <= 3'(bpLast) + 3'h1;
      driveCtrl.backplaneIdx <= bpIdx;
      driveCtrl.lowPowerWave <= frameReg[FR_LPW_BIT];
      driveCtrl.blinkAll     <= blinkReg[BL_MODE_BIT];
      driveCtrl.blinkPhase   <= blinkPhase;
      driveCtrl.frameTick    <= frameTick;
    end
  end

  // Only enabled pins are frontplanes, and only while driving
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      frontplaneDrive <= '0;
    end else begin
      frontplaneDrive <= active ? fpEnable : '0;
    end
  end

endmodule

//--- rtl/lcd_cfg_pkg.sv
// Purpose: Shared constants and types of the LCD configuration block
// Assumes: 8-bit register port, 4-bit register index
// Notes:   Register indices are word indices on the plain port
package lcd_cfg_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int FP_NUM = 41;

  // Register indices
  localparam logic [3:0] IDX_CLOCK_SELECT  = 4'h0;
  localparam logic [3:0] IDX_SUPPLY        = 4'h1;
  localparam logic [3:0] IDX_LOW_POWER     = 4'h2;
  localparam logic [3:0] IDX_FRAME         = 4'h3;
  localparam logic [3:0] IDX_BLINK         = 4'h4;
  localparam logic [3:0] IDX_FRONTPLANE_0  = 4'h5;
  localparam logic [3:0] IDX_FRONTPLANE_5  = 4'ha;

  // Clock select fields
  localparam int CLK_SOURCE_BIT = 7;
  localparam int CLK_PRESCALE_BY_SIXTEEN_BIT  = 6;
  localparam int CLK_ADJ_MSB    = 5;

  // Supply control fields
  localparam int SUP_PUMP_EN_BIT  = 7;
  localparam int SUP_PUMP_MUL_BIT = 6;
  localparam int SUP_PCLK_MSB     = 5;
  localparam int SUP_PCLK_LSB     = 4;
  localparam int SUP_HDRV_BIT     = 3;
  localparam int SUP_BYPASS_BIT   = 2;
  localparam int SUP_SRC_MSB      = 1;

  // Low power control fields
  localparam int LP_WAIT_DIS_BIT  = 1;
  localparam int LP_STOP3_DIS_BIT = 0;

  // Frame control fields
  localparam int FR_CLK_MSB   = 5;
  localparam int FR_CLK_LSB   = 3;
  localparam int FR_LPW_BIT   = 2;
  localparam int FR_DUTY_MSB  = 1;
  localparam logic [7:0] FR_MASK = 8'h3f;

  // Blink control fields
  localparam int BL_MODE_BIT  = 3;
  localparam int BL_RATE_MSB  = 2;
  localparam logic [7:0] BL_MASK = 8'h0f;

  // Last frontplane register holds only bit 0
  localparam logic [7:0] FP5_MASK = 8'h01;

  // Supply source and duty codes
  localparam logic [1:0] SUP_SECOND_BIAS = 2'h0;
  localparam logic [1:0] SUP_THIRD_BIAS  = 2'h1;
  localparam logic [1:0] SUP_EXTERNAL    = 2'h2;
  localparam logic [1:0] DUTY_QUARTER    = 2'h3;
  localparam logic [1:0] DUTY_THIRD      = 2'h2;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // Prescale constants
  localparam logic [3:0] PRE16_LAST  = 4'hf;
  localparam logic [7:0] FRAME_ONE   = 8'h02;
  localparam logic [9:0] BLINK_ONE   = 10'h004;

  typedef struct packed {
    logic       lcdActive;
    logic       pumpOn;
    logic       pumpTripler;
    logic [1:0] pumpClockSel;
    logic       highDrive;
    logic       bufferBypass;
    logic       secondBiasInternal;
    logic       thirdBiasInternal;
    logic       externalSupply;
    logic       quarterDuty;
    logic [2:0] backplaneCount;
    logic [1:0] backplaneIdx;
    logic       lowPowerWave;
    logic       blinkAll;
    logic       blinkPhase;
    logic       frameTick;
  } lcd_drive_t;

endpackage

//--- verif/lcd_driver_config_regs_asserts.sv
// Purpose: Port timing relations of the LCD register block
// Assumes: One clock, sync active-high reset
// Notes:   Bound from the bench top
module lcd_driver_config_regs_asserts
  import lcd_cfg_pkg::*;
(
  // Clock and reset
  input wire logic                         mclk,
  input wire logic                         sys_rst,
  // Register port
  input wire logic [lcd_cfg_pkg::ADDR_W-1:0] regAddr,
  input wire logic [lcd_cfg_pkg::DATA_W-1:0] regWrData,
  input wire logic                         regWrite,
  input wire logic                         regRead,
  input wire logic [lcd_cfg_pkg::DATA_W-1:0] regRdData,
  // Modes and drive
  input wire logic                         waitMode,
  input wire logic                         stop3Mode,
  input lcd_cfg_pkg::lcd_drive_t           driveCtrl,
  input wire logic [lcd_cfg_pkg::FP_NUM-1:0] frontplaneDrive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic supW;
  assign supW = regWrite && regAddr == IDX_SUPPLY;
  property p_rd_idle;
    !regRead |=> regRdData == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero after idle cycle");
  property p_pump;
    supW ##1 !supW |=> driveCtrl.pumpOn == $past(regWrData[7], 2);
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump enable does not follow write");
  property p_pclk;
    supW ##1 !supW |=> {driveCtrl.pumpClockSel, driveCtrl.bufferBypass}
      == {$past(regWrData[5:4], 2), $past(regWrData[2], 2)};
  endproperty
  a_pclk: assert property (p_pclk)
    else $error("pump clock or bypass does not follow write");
  property p_ext;
    supW ##1 !supW |=> driveCtrl.externalSupply
      == ($past(regWrData[1:0], 2) == SUP_EXTERNAL);
  endproperty
  a_ext: assert property (p_ext)
    else $error("external supply flag wrong");
  property p_trip;
    driveCtrl.pumpTripler |-> !driveCtrl.secondBiasInternal;
  endproperty
  a_trip: assert property (p_trip)
    else $error("tripler set while powered from main supply");
  property p_duty;
    driveCtrl.quarterDuty |-> driveCtrl.backplaneCount == 3'h4;
  endproperty
  a_duty: assert property (p_duty)
    else $error("quarter duty without four backplanes");
  property p_fp_off;
    !driveCtrl.lcdActive |-> frontplaneDrive == '0;
  endproperty
  a_fp_off: assert property (p_fp_off)
    else $error("frontplanes driven while display stopped");
  property p_awake;
    !waitMode && !stop3Mode |=> driveCtrl.lcdActive;
  endproperty
  a_awake: assert property (p_awake)
    else $error("display stopped outside low power modes");
  property p_tick;
    driveCtrl.frameTick |=> !driveCtrl.frameTick;
  endproperty
  a_tick: assert property (p_tick)
    else $error("frame tick longer than one cycle");
endmodule

//--- verif/lcd_glass_model.sv
// Purpose: Segment glass as seen from the drive outputs
// Assumes: Frame tick marks a frame boundary
// Notes:   Counts frames and blink flips; no analog behaviour
module lcd_glass_model
  import lcd_cfg_pkg::*;
(
  // Clock
  input wire logic               mclk,
  // Drive from the block
  input lcd_cfg_pkg::lcd_drive_t driveCtrl,
  // Observed activity
  output int                     frames,
  output int                     blinks
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lastBlink = '0;
  initial frames = 0;
  initial blinks = 0;
  always @(posedge mclk) begin
    if (driveCtrl.frameTick)
      frames <= frames + 1;
    if (driveCtrl.blinkPhase !== lastBlink)
      blinks <= blinks + 1;
    lastBlink <= driveCtrl.blinkPhase;
  end
endmodule

//--- verif/tb_lcd_driver_config_regs.sv
// Purpose: Self-checking bench of the LCD register block
// Assumes: Bench model of registers and divider laws
// Notes:   Rate checks allow slack for divider phase at start
module tb_lcd_driver_config_regs import lcd_cfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = '0, sys_rst = 1'h1, regWrite = '0, regRead = '0;
  logic extRefClk = '0, waitMode = '0, stop3Mode = '0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0, regRdData;
  lcd_drive_t driveCtrl;
  logic [FP_NUM-1:0] frontplaneDrive;
  int numErrors = 0, totalChecks = 0, cycles = 0, frames, blinks, d;
  int regModel [16];
  lcd_driver_config_regs dut(.mclk, .sys_rst, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .extRefClk, .waitMode,
    .stop3Mode, .driveCtrl, .frontplaneDrive);
  lcd_glass_model glass(.mclk, .driveCtrl, .frames, .blinks);
  initial forever #20 mclk = ~mclk;
  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    totalChecks++;
    if (e !== s) begin
      numErrors++;
      $display("MISMATCH %s exp %0h got %0h", n, e, s);
    end
  endtask
  function automatic int msk(int a);
    case (a)
      2: return 8'h03;
      3: return 8'h3f;
      4: return 8'h0f;
      10: return 8'h01;
      default: return a < 10 ? 8'hff : 8'h00;
    endcase
  endfunction
  function automatic logic [63:0] fpExp();
    fpExp = '0;
    for (int k = 0; k < 41; k++)
      fpExp[k] = regModel[5 + k / 8][k % 8];
  endfunction
  task automatic wr(int a, int v);
    @(posedge mclk);
    regAddr <= a[3:0];
    regWrData <= v[7:0];
    regWrite <= 1'h1;
    @(posedge mclk);
    regWrite <= '0;
    regModel[a] = v & msk(a);
  endtask
  task automatic rd(int a);
    @(posedge mclk);
    regAddr <= a[3:0];
    regRead <= 1'h1;
    @(posedge mclk);
    regRead <= '0;
    #1 chk("regRdData", regModel[a], regRdData);
  endtask
  task automatic w2();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // Ext ticks counted as the block samples them: low then high
  task automatic meas(int cs, int fr, int br);
    int f0, b0, ticks, fe;
    bit v;
    wr(0, cs);
    wr(3, fr << 3);
    wr(4, br);
    f0 = frames;
    b0 = blinks;
    ticks = 0;
    repeat (640) begin
      @(posedge mclk);
      v = $urandom;
      ticks += v && !extRefClk;
      extRefClk <= v;
    end
    if (cs[7])
      ticks = 640;
    fe = ticks / ((cs % 64 + 1) << (fr + 1)) / (cs[6] ? 16 : 1);
    chk("frames near", 1, (frames - f0 - fe) inside {[-2:2]});
    fe = fe / (1 << (br + 2));
    chk("blinks near", 1, (blinks - b0 - fe) inside {[-1:1]});
    chk("backplaneIdx", 0, driveCtrl.backplaneIdx);
  endtask
  task automatic report_and_stop();
    if (numErrors == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(74));
    regModel = '{default: 0};
    repeat (4) @(posedge mclk);
    sys_rst <= '0;
    for (int a = 0; a < 16; a++) begin
      rd(a);
      wr(a, $urandom);
    end
    for (int a = 0; a < 16; a++)
      rd(a);
    for (int s = 0; s < 4; s++) begin
      d = $urandom;
      d[1:0] = s;
      wr(1, d);
      w2();
      chk("pumpOn", d[7], driveCtrl.pumpOn);
      chk("pumpTripler", d[6] && s != 0, driveCtrl.pumpTripler);
      chk("pumpClockSel", d[5:4], driveCtrl.pumpClockSel);
      chk("bufferBypass", d[2], driveCtrl.bufferBypass);
      chk("highDrive", d[3], driveCtrl.highDrive);
      chk("bias", {s == 0, s == 1, s == 2}, {driveCtrl.secondBiasInternal,
        driveCtrl.thirdBiasInternal, driveCtrl.externalSupply});
    end
    for (int t = 0; t < 4; t++) begin
      wr(3, t | t << 2);
      wr(4, t << 3);
      w2();
      chk("quarterDuty", t == 3, driveCtrl.quarterDuty);
      chk("backplaneCount", t + 1, driveCtrl.backplaneCount);
      chk("blinkAll", t[0], driveCtrl.blinkAll);
      chk("lowPowerWave", t[0], driveCtrl.lowPowerWave);
    end
    for (int i = 0; i < 16; i++) begin
      wr(2, i);
      waitMode <= i[2];
      stop3Mode <= i[3];
      w2();
      d = !(i[2] && i[1]) && !(i[3] && i[0]);
      chk("lcdActive", d, driveCtrl.lcdActive);
      chk("frontplaneDrive", d ? fpExp() : 0, frontplaneDrive);
    end
    @(posedge mclk);
    waitMode <= '0;
    stop3Mode <= '0;
    meas(8'h80, 0, 0);
    meas(8'h83, 1, 1);
    meas(8'hc0, 0, 0);
    meas(8'h00, 0, 0);
    report_and_stop();
  end
endmodule
bind lcd_driver_config_regs lcd_driver_config_regs_asserts sva(.mclk,
  .sys_rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
  .waitMode, .stop3Mode, .driveCtrl, .frontplaneDrive);
